// file: tb.sv
// Self-checking testbench for the tick down counter
`default_nettype none
module tb
  import tdc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic         clk = 1'b0;
  logic         reset = 1'b1;
  tdc_bus_req_t bus_req = '0;
  logic [31:0]  rdata;
  logic         int_tick = 1'b0;
  logic         ext_clk_pin = 1'b0;
  logic         irq;
  logic         wake;
  int           failures = 0;
  int           n_compared = 0;
  int           n_wake = 0;
  logic [31:0]  rv;
  always #50 clk = ~clk;
  // Count wake pulses seen on the output
  always @(posedge clk)
    if (wake)
      n_wake <= n_wake + 1;
  tdc_timer dut (.clk(clk), .reset(reset), .bus_req(bus_req),
    .rdata(rdata), .int_tick(int_tick), .ext_clk_pin(ext_clk_pin),
    .irq(irq), .wake(wake));
  //////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("Compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1 rv = rdata;
  endtask : rd
  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input logic [31:0] m = 32'hFFFFFFFF);
    rd(a);
    cmp(rv & m, e);
  endtask : rdc
  task automatic pulse(input bit ext, input int n);
    repeat (n)
    begin
      @(posedge clk);
      if (ext)
      begin
        ext_clk_pin <= 1'b1;
        repeat (4) @(posedge clk);
        ext_clk_pin <= 1'b0;
        repeat (4) @(posedge clk);
      end
      else
      begin
        int_tick <= 1'b1;
        @(posedge clk);
        int_tick <= 1'b0;
      end
    end
  endtask : pulse
  task automatic prime(input bit ext, input logic [31:0] t);
    for (int i = 0; i < 4; i++)
    begin
      rd(TDC_COUNT_ADDR);
      if (rv === t)
        return;
      pulse(ext, 1);
    end
    failures++;
    end_of_test();
  endtask : prime
  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    for (int a = 0; a <= 'h18; a += 4)
      if (a != 'h14)
        rdc(a[7:0], 32'h0);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_single;
    wr(TDC_CMD_ADDR, 32'h02);
    wr(TDC_MODE_ADDR, 32'h2);
    wr(TDC_REF_ADDR, 32'h5);
    wr(TDC_CMD_ADDR, 32'h04);
    rdc(TDC_CTRL_ADDR, 32'h3);
    prime(1'b0, 32'h5);
    pulse(1'b0, 2);
    rdc(TDC_COUNT_ADDR, 32'h3);
    rdc(TDC_COUNT_ADDR, 32'h3);
    pulse(1'b0, 5);
    rdc(TDC_COUNT_ADDR, 32'h0);
    rdc(TDC_STATUS_ADDR, 32'h3, 32'h3);
    cmp({31'h0, irq}, 32'h1);
    cmp(n_wake, 32'h1);
    wr(TDC_REF_ADDR, 32'h2);
    pulse(1'b0, 1);
    rdc(TDC_COUNT_ADDR, 32'h1);
    wr(TDC_CMD_ADDR, 32'h08);
    @(posedge clk);
    #1 cmp({31'h0, irq}, 32'h0);
    rdc(TDC_STATUS_ADDR, 32'h1, 32'h3);
    wr(TDC_CMD_ADDR, 32'h10);
    rdc(TDC_STATUS_ADDR, 32'h0, 32'h3);
    $display("t_single done");
  endtask : t_single
  task automatic t_reload;
    wr(TDC_CMD_ADDR, 32'h02);
    wr(TDC_MODE_ADDR, 32'h1);
    wr(TDC_REF_ADDR, 32'h2);
    wr(TDC_CMD_ADDR, 32'h04);
    wr(TDC_CTRL_ADDR, 32'h1);
    prime(1'b0, 32'h2);
    pulse(1'b0, 2);
    rdc(TDC_STATUS_ADDR, 32'h1, 32'h3);
    cmp({31'h0, irq}, 32'h0);
    cmp(n_wake, 32'h1);
    pulse(1'b0, 1);
    rdc(TDC_COUNT_ADDR, 32'h2);
    wr(TDC_CMD_ADDR, 32'h02);
    pulse(1'b0, 3);
    rdc(TDC_COUNT_ADDR, 32'h2);
    rdc(TDC_MODE_ADDR, 32'h0);
    wr(TDC_CMD_ADDR, 32'h01);
    rdc(TDC_COUNT_ADDR, 32'h0);
    $display("t_reload done");
  endtask : t_reload
  task automatic t_ext;
    wr(TDC_CTRL_ADDR, 32'h0);
    wr(TDC_REF_ADDR, 32'h3);
    wr(TDC_MODE_ADDR, 32'h1);
    int_tick <= 1'b1;
    prime(1'b1, 32'h3);
    pulse(1'b1, 1);
    rdc(TDC_COUNT_ADDR, 32'h2);
    int_tick <= 1'b0;
    wr(TDC_MODE_ADDR, 32'h3);
    pulse(1'b1, 2);
    rdc(TDC_COUNT_ADDR, 32'h2);
    $display("t_ext done");
  endtask : t_ext
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_single();
    t_reload();
    t_ext();
    end_of_test();
  end
endmodule : tb
`default_nettype wire

// file: tdc_pkg.sv
// Package for the tick down counter: register map, fields, modes, structs
`default_nettype none
package tdc_pkg;

  // Register offsets (byte addresses, one word each)
  localparam logic [7:0] TDC_MODE_ADDR   = 8'h00;
  localparam logic [7:0] TDC_REF_ADDR    = 8'h04;
  localparam logic [7:0] TDC_COUNT_ADDR  = 8'h08;
  localparam logic [7:0] TDC_CTRL_ADDR   = 8'h0C;
  localparam logic [7:0] TDC_STATUS_ADDR = 8'h10;
  localparam logic [7:0] TDC_CMD_ADDR    = 8'h14;

  // Field positions
  localparam int TDC_CTRL_SRC_BIT    = 0;
  localparam int TDC_CTRL_IRQEN_BIT  = 1;
  localparam int TDC_STAT_WRAP_BIT   = 0;
  localparam int TDC_STAT_PEND_BIT   = 1;
  localparam int TDC_STAT_RUN_BIT    = 2;
  localparam int TDC_CMD_CLEAR_BIT   = 0;
  localparam int TDC_CMD_STOP_BIT    = 1;
  localparam int TDC_CMD_INIT_BIT    = 2;
  localparam int TDC_CMD_PENDCLR_BIT = 3;
  localparam int TDC_CMD_WRAPCLR_BIT = 4;

  // Reset values
  localparam logic [23:0] TDC_REF_RESET   = 24'h000000;
  localparam logic [23:0] TDC_COUNT_RESET = 24'h000000;
  localparam logic        TDC_SRC_RESET   = 1'b0;
  localparam logic        TDC_IRQEN_RESET = 1'b0;

  // Operating modes
  typedef enum logic [1:0] {
    mode_off            = 2'b00,
    mode_reload_on_zero = 2'b01,
    mode_single_shot    = 2'b10
  } tdc_mode_t;

  // Register bus request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } tdc_bus_req_t;

endpackage : tdc_pkg
`default_nettype wire

// file: tdc_properties.sv
// Port checker for the tick down counter
`default_nettype none
module tdc_properties
  import tdc_pkg::*;
(
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  reset,
  // Register port
  input wire tdc_pkg::tdc_bus_req_t bus_req,
  input wire logic [31:0]           rdata,
  // Counting clocks
  input wire logic                  int_tick,
  input wire logic                  ext_clk_pin,
  // Interrupt and wake
  input wire logic                  irq,
  input wire logic                  wake
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  //////////////////////////////////////////////////////////////////////////
  logic pclr;
  assign pclr = bus_req.wr && bus_req.addr == TDC_CMD_ADDR
                && bus_req.wdata[TDC_CMD_PENDCLR_BIT];
  sequence s_pend_clr;
    pclr ##1 !wake;
  endsequence
  a_rdata_idle_zero: assert property (
    !bus_req.rd |=> rdata == 32'h0) else $error("rdata not zero");
  a_count_upper_zero: assert property (
    bus_req.rd && bus_req.addr == TDC_COUNT_ADDR |=> rdata[31:24] == 8'h00)
    else $error("count wider than 24 bits");
  a_wake_one_cycle: assert property (
    wake |=> !wake) else $error("wake longer than one cycle");
  a_wake_sets_irq: assert property (
    wake |-> irq) else $error("irq missing after zero event");
  a_irq_holds: assert property (
    irq && !pclr && !$past(pclr) |=> irq) else $error("irq dropped");
  a_pend_clear: assert property (
    s_pend_clr |-> !irq) else $error("irq not cleared");
  a_irq_from_wake: assert property (
    $rose(irq) |-> wake) else $error("irq without zero event");
  a_reset_quiet: assert property (
    $fell(reset) |-> !irq && !wake && rdata == 32'h0)
    else $error("outputs active after reset");
endmodule : tdc_properties
bind tdc_timer tdc_properties u_props (.clk(clk), .reset(reset),
  .bus_req(bus_req), .rdata(rdata), .int_tick(int_tick),
  .ext_clk_pin(ext_clk_pin), .irq(irq), .wake(wake));
`default_nettype wire

// file: tdc_timer.sv
// Tick down counter: 24-bit down counter with register port
//
// Function
// - While enabled, count decrements by one on each selected-clock tick.
// - Reload mode reloads the reference at zero and keeps counting.
// - Single-shot mode stops and holds at zero.
// - A third mode value disables the timer entirely.
// - Counting starts once an enabling mode is written, whatever the count.
// - After reset the timer is disabled.
// - In single-shot at zero, writing reference restarts counting from it.
// - Reference count is unsigned 24 bits, zero to all ones.
// - With interrupts enabled, interrupt raised on the one-to-zero edge.
// - Clear command forces the count to zero.
// - Count read returns present value without disturbing counting.
// - Stop command disables the timer; no further decrements.
// - Readable wrap flag set once counter counts one to zero.
// - Source select bit: set picks internal clock, clear picks external.
// - Init enables interrupt, selects internal clock and clears the single-shot halt; it leaves the mode unchanged.
// - Interrupt enable bit gates the zero-reached interrupt.
// - Timer interrupt can wake the processor from doze.
// - Readable pending bit true while interrupt pending.
// - Pending-clear command removes any pending interrupt.
`default_nettype none
module tdc_timer
  import tdc_pkg::*;
#(
  parameter int COUNT_W = 24
)
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // Register port
  input  wire tdc_pkg::tdc_bus_req_t bus_req,
  output var  logic [31:0]       rdata,
  // Counting clocks: internal tick enable and external pin
  input  wire logic              int_tick,
  input  wire logic              ext_clk_pin,
  // Interrupt and doze wake
  output var  logic              irq,
  output var  logic              wake
);
  import tdc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  tdc_mode_t          mode;
  logic [COUNT_W-1:0] ref_count;
  logic [COUNT_W-1:0] count;
  logic               clock_source_select;
  logic               irq_enable;
  logic               wrap_flag;
  logic               pending;
  logic               stopped;
  logic [2:0]         ext_sync;
  logic               ext_level;
  logic               tick;
  logic               wr_mode;
  logic               wr_ref;
  logic               wr_ctrl;
  logic               wr_cmd;
  logic               cmd_clear;
  logic               cmd_stop;
  logic               cmd_init;
  logic               cmd_pendclr;
  logic               cmd_wrapclr;
  logic               zero_event;
  logic               running;

  ////////////////////////////////////////////////////////////////////////////
  // External clock synchroniser and edge detect
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ext_sync  <= 3'h0;
      ext_level <= 1'b0;
    end
    else
    begin
      ext_sync <= {ext_sync[1:0], ext_clk_pin};
      if (ext_sync[1] == ext_sync[2])
      begin
        ext_level <= ext_sync[2];
      end
    end
  end

  // Tick from the selected source
  assign tick = clock_source_select ? int_tick
              : (ext_sync[1] == ext_sync[2]) && ext_sync[2] && !ext_level;

  ////////////////////////////////////////////////////////////////////////////
  // Write decode
  assign wr_mode     = bus_req.wr && (bus_req.addr == TDC_MODE_ADDR);
  assign wr_ref      = bus_req.wr && (bus_req.addr == TDC_REF_ADDR);
  assign wr_ctrl     = bus_req.wr && (bus_req.addr == TDC_CTRL_ADDR);
  assign wr_cmd      = bus_req.wr && (bus_req.addr == TDC_CMD_ADDR);
  assign cmd_clear   = wr_cmd && bus_req.wdata[TDC_CMD_CLEAR_BIT];
  assign cmd_stop    = wr_cmd && bus_req.wdata[TDC_CMD_STOP_BIT];
  assign cmd_init    = wr_cmd && bus_req.wdata[TDC_CMD_INIT_BIT];
  assign cmd_pendclr = wr_cmd && bus_req.wdata[TDC_CMD_PENDCLR_BIT];
  assign cmd_wrapclr = wr_cmd && bus_req.wdata[TDC_CMD_WRAPCLR_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Mode register
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      mode <= mode_off;
    end
    else if (cmd_stop)
    begin
      mode <= mode_off;
    end
    else if (wr_mode)
    begin
      unique case (bus_req.wdata[1:0])
        2'b01:   mode <= mode_reload_on_zero;
        2'b10:   mode <= mode_single_shot;
        default: mode <= mode_off;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reference register
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ref_count <= TDC_REF_RESET;
    end
    else if (wr_ref)
    begin
      ref_count <= bus_req.wdata[COUNT_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register and init command
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      clock_source_select <= TDC_SRC_RESET;
      irq_enable          <= TDC_IRQEN_RESET;
    end
    else if (cmd_init)
    begin
      clock_source_select <= 1'b1;
      irq_enable          <= 1'b1;
    end
    else if (wr_ctrl)
    begin
      clock_source_select <= bus_req.wdata[TDC_CTRL_SRC_BIT];
      irq_enable          <= bus_req.wdata[TDC_CTRL_IRQEN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Single-shot halt state
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      stopped <= 1'b0;
    end
    else if (wr_ref || wr_mode || cmd_init)
    begin
      stopped <= 1'b0;
    end
    else if (mode == mode_single_shot && tick && count == 24'h000001)
    begin
      stopped <= 1'b1;
    end
  end

  assign running    = (mode != mode_off) && !stopped;
  assign zero_event = running && tick && (count == 24'h000001);

  ////////////////////////////////////////////////////////////////////////////
  // Counter
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      count <= TDC_COUNT_RESET;
    end
    else if (cmd_clear)
    begin
      count <= TDC_COUNT_RESET;
    end
    else if (wr_ref && mode == mode_single_shot && stopped)
    begin
      count <= bus_req.wdata[COUNT_W-1:0];
    end
    else if (running && tick)
    begin
      if (count == 24'h000000)
      begin
        if (mode == mode_reload_on_zero)
        begin
          count <= ref_count;
        end
        else if (ref_count != 24'h000000)
        begin
          count <= ref_count;
        end
      end
      else if (count == 24'h000001 && mode == mode_reload_on_zero)
      begin
        count <= 24'h000000;
      end
      else
      begin
        count <= count - 24'h000001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wrap and pending flags; set wins over clear
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      wrap_flag <= 1'b0;
      pending   <= 1'b0;
    end
    else
    begin
      if (zero_event)
      begin
        wrap_flag <= 1'b1;
      end
      else if (cmd_wrapclr)
      begin
        wrap_flag <= 1'b0;
      end
      if (zero_event && irq_enable)
      begin
        pending <= 1'b1;
      end
      else if (cmd_pendclr)
      begin
        pending <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt and wake outputs
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      irq  <= 1'b0;
      wake <= 1'b0;
    end
    else
    begin
      irq  <= (pending && !cmd_pendclr) || (zero_event && irq_enable);
      wake <= zero_event && irq_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      rdata <= 32'h00000000;
    end
    else if (bus_req.rd)
    begin
      unique case (bus_req.addr)
        TDC_MODE_ADDR:   rdata <= {30'h0, mode};
        TDC_REF_ADDR:    rdata <= {8'h00, ref_count};
        TDC_COUNT_ADDR:  rdata <= {8'h00, count};
        TDC_CTRL_ADDR:   rdata <= {30'h0, irq_enable, clock_source_select};
        TDC_STATUS_ADDR: rdata <= {29'h0, running, pending, wrap_flag};
        default:         rdata <= 32'h00000000;
      endcase
    end
    else
    begin
      rdata <= 32'h00000000;
    end
  end

endmodule : tdc_timer
`default_nettype wire
